/* design/cnp_pkg.sv */
// package for the chain node port and state logic
package cnp_pkg;
  typedef enum logic [2:0] {
    CNP_ST_POR,
    CNP_ST_DETECT,
    CNP_ST_UNCONF,
    CNP_ST_SLEEP,
    CNP_ST_ACTIVE,
    CNP_ST_LOWPWR
  } cnp_state_e;
  typedef enum logic [1:0] {
    CNP_MODE_DIFF,
    CNP_MODE_MCU,
    CNP_MODE_EOC,
    CNP_MODE_XCVR
  } cnp_mode_e;
  // command codes on the decoded command port
  localparam logic [3:0] CMD_ENUMERATE = 4'h1;
  localparam logic [3:0] CMD_RESET = 4'h2;
  localparam logic [3:0] CMD_CLEAR_FAULTS = 4'h3;
  localparam logic [3:0] CMD_SET_OT = 4'h4;
  localparam logic [3:0] CMD_WRITE_SETUP = 4'h5;
  localparam logic [3:0] CMD_WRITE_DUTY = 4'h6;
  localparam logic [3:0] CMD_SLEEP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h8;
  localparam logic [3:0] CMD_LOW_POWER = 4'h9;
  localparam int CLK_MHZ = 125;
  localparam int STARTUP_US = 1000;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int DETECT_US = 40;
  localparam int DETECT_CYC = DETECT_US * CLK_MHZ;
  localparam int UP_DIV = 16;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [15:0] DUTY_MIN = 16'h0010;
  localparam int NUM_CH = 3;
  localparam int FRAME_BITS = 8;
  localparam int MAN_HALF = 16;
endpackage

/* design/cnp_man_rx.sv */
// manchester receiver: one bit per full period, decided on the mid-bit edge
`timescale 1ns/1ns
module cnp_man_rx #(
  parameter int HALF = cnp_pkg::MAN_HALF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic line_in,
  output logic bit_valid,
  output logic bit_value
);
  logic prev_reg, prev_next;
  logic [7:0] cnt_reg, cnt_next;
  logic bv_reg, bv_next;
  logic bd_reg, bd_next;
  localparam logic [7:0] WIN = 8'((HALF * 3) / 2);

  always_comb begin
    prev_next = line_in;
    cnt_next = (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
    bv_next = 1'b0;
    bd_next = bd_reg;
    if (!enable) begin
      cnt_next = 8'hFF;
    end else if (line_in != prev_reg) begin
      // edges closer than 1.5 half-periods are bit-boundary edges, ignored
      if (cnt_reg >= WIN) begin
        bv_next = 1'b1;
        bd_next = line_in;
        cnt_next = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b0;
      cnt_reg <= 8'hFF;
      bv_reg <= 1'b0;
      bd_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      bv_reg <= bv_next;
      bd_reg <= bd_next;
    end
  end

  assign bit_valid = bv_reg;
  assign bit_value = bd_reg;
endmodule

/* design/cnp_node.sv */
// chain node port modes, startup sequence and device state machine
// Summary of operation
// R1 - in host mode the host sends manchester data on the positive pin
// R2 - in host mode the negative pin is ignored on receive
// R3 - upstream sends data on positive pin, clock on negative, with start and stop
// R4 - upstream clock polarity is invertible by command
// R5 - both pins driven to strap idle levels before and after upstream messages
// R6 - both pins pulled up at detection selects transceiver mode
// R7 - transceiver mode: positive pin is manchester output only
// R8 - transceiver mode: negative pin is manchester input, ignored while sending
// R9 - the transceiver must carry at least 4.8 Mbit/s
// R10 - both pins pulled down at detection selects differential mode
// R11 - a single-port host must turn around fast enough for the reply
// R12 - after power-up: unconfigured, duty values zero, drivers off
// R13 - unconfigured accepts only enumerate and listed broadcast commands
// R14 - broadcasts forwarded as they arrive, addressed ones after full receipt
// R15 - sleep entered on enumerate, sleep command or fault with fault-to-sleep
// R16 - sleep keeps drivers off and duty values, still accepts updates
// R17 - active entered on active command only with no fault present
// R18 - active drives each channel from its settings, accepts updates
// R19 - on entering active, one open/short check per channel above minimum
// R20 - low-power command accepted, behaves like sleep
// R21 - host waits about 1 ms, sends setup, then enumerate
// R22 - strapping sampled after every reset command and power-on
// R23 - end-of-chain strap marks the node as last in chain
// R24 - startup sequence finishes in about 1 ms
`timescale 1ns/1ns
module cnp_node #(
  parameter int STARTUP_CYCLES = cnp_pkg::STARTUP_CYC,
  parameter int DETECT_CYCLES = cnp_pkg::DETECT_CYC,
  parameter int NCH = cnp_pkg::NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_pin_pos_in,
  output logic serial_pin_pos_out,
  output logic serial_pin_pos_oe,
  input wire logic serial_pin_neg_in,
  output logic serial_pin_neg_out,
  output logic serial_pin_neg_oe,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_broadcast,
  input wire logic [1:0] cmd_channel,
  input wire logic [15:0] cmd_data,
  input wire logic fault_present,
  input wire logic fault_event,
  input wire logic up_valid,
  input wire logic [7:0] up_data,
  output logic up_ready,
  output logic rx_bit_valid,
  output logic rx_bit_value,
  output logic fwd_now,
  output logic fwd_after,
  output logic [2:0] node_state,
  output logic [1:0] port_mode,
  output logic last_in_chain,
  output logic [NCH-1:0] driver_en,
  output logic [NCH*16-1:0] duty_out,
  output logic [NCH-1:0] check_start
);
  localparam logic [31:0] ST_CYC = 32'(STARTUP_CYCLES);
  localparam logic [31:0] DT_CYC = 32'(DETECT_CYCLES);
  localparam logic [4:0] DIV_LAST = 5'(cnp_pkg::UP_DIV - 1);
  localparam logic [3:0] BITS_LAST = 4'(cnp_pkg::FRAME_BITS - 1);
  localparam logic [4:0] DIV_HALF = 5'(cnp_pkg::UP_DIV / 2);

  // two-stage synchronisers on both pins
  logic [1:0] p_sync, n_sync;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p_sync <= 2'h0;
      n_sync <= 2'h0;
    end else begin
      p_sync <= {p_sync[0], serial_pin_pos_in};
      n_sync <= {n_sync[0], serial_pin_neg_in};
    end
  end

  cnp_pkg::cnp_state_e st_reg, st_next;
  cnp_pkg::cnp_mode_e mode_reg, mode_next;
  logic [31:0] tmr_reg, tmr_next;
  logic pol_reg, pol_next, f2s_reg, f2s_next;
  logic [NCH*16-1:0] duty_reg, duty_next;
  logic [NCH-1:0] drv_reg, drv_next, chk_reg, chk_next, done_reg, done_next;
  logic fnow_reg, fnow_next, faft_reg, faft_next, lic_reg, lic_next;
  // upstream sender
  typedef enum logic [1:0] {CNP_UP_IDLE, CNP_UP_START, CNP_UP_DATA, CNP_UP_STOP} cnp_up_e;
  cnp_up_e up_reg, up_next;
  logic [4:0] div_reg, div_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic po_reg, po_next, no_reg, no_next, poe_reg, poe_next, noe_reg, noe_next, rdy_reg, rdy_next;
  logic idle_p, idle_n, tick, rx_line, rx_en, cmd_ok;

  assign tick = (div_reg == DIV_LAST);
  // negative pin never feeds the host-mode receiver; see R2
  assign rx_line = (mode_reg == cnp_pkg::CNP_MODE_XCVR) ? n_sync[1] : p_sync[1]; // see R8
  assign rx_en = (st_reg != cnp_pkg::CNP_ST_POR) && (st_reg != cnp_pkg::CNP_ST_DETECT)
    && (mode_reg != cnp_pkg::CNP_MODE_EOC)
    && !(mode_reg == cnp_pkg::CNP_MODE_XCVR && up_reg != CNP_UP_IDLE); // see R8

  cnp_man_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(rx_en),
    .line_in(rx_line),
    .bit_valid(rx_bit_valid),
    .bit_value(rx_bit_value)
  );

  // idle levels follow the strap: host mode rests pos high/neg low, end-of-chain the reverse
  always_comb begin
    idle_p = (mode_reg != cnp_pkg::CNP_MODE_EOC);
    idle_n = (mode_reg == cnp_pkg::CNP_MODE_EOC); // polarity only applies inside a frame; see R5
  end

  // command acceptance filter
  always_comb begin
    cmd_ok = 1'b1;
    if (st_reg == cnp_pkg::CNP_ST_UNCONF) begin // see R13
      unique case (cmd_code)
        cnp_pkg::CMD_ENUMERATE: cmd_ok = 1'b1;
        cnp_pkg::CMD_RESET, cnp_pkg::CMD_CLEAR_FAULTS, cnp_pkg::CMD_SET_OT,
        cnp_pkg::CMD_WRITE_SETUP, cnp_pkg::CMD_WRITE_DUTY: cmd_ok = cmd_broadcast;
        default: cmd_ok = 1'b0;
      endcase
    end else if (st_reg == cnp_pkg::CNP_ST_POR || st_reg == cnp_pkg::CNP_ST_DETECT) begin
      cmd_ok = 1'b0;
    end
  end

  // state machine
  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    tmr_next = tmr_reg + 32'h1;
    pol_next = pol_reg;
    f2s_next = f2s_reg;
    duty_next = duty_reg;
    chk_next = '0;
    done_next = done_reg;
    fnow_next = 1'b0;
    faft_next = 1'b0;
    if (cmd_valid) begin
      fnow_next = cmd_broadcast; // see R14
      faft_next = !cmd_broadcast; // see R14
    end
    unique case (st_reg)
      cnp_pkg::CNP_ST_POR: begin
        if (tmr_reg >= ST_CYC - DT_CYC) begin
          st_next = cnp_pkg::CNP_ST_DETECT;
          tmr_next = 32'h0;
        end
      end
      cnp_pkg::CNP_ST_DETECT: begin
        if (tmr_reg >= DT_CYC - 32'h1) begin // see R24
          unique case ({p_sync[1], n_sync[1]}) // see R22
            2'b11: mode_next = cnp_pkg::CNP_MODE_XCVR; // see R6
            2'b00: mode_next = cnp_pkg::CNP_MODE_DIFF; // see R10
            2'b10: mode_next = cnp_pkg::CNP_MODE_MCU;
            2'b01: mode_next = cnp_pkg::CNP_MODE_EOC; // see R23
          endcase
          st_next = cnp_pkg::CNP_ST_UNCONF; // see R12
        end
      end
      default: begin
        if (fault_event && f2s_reg && st_reg == cnp_pkg::CNP_ST_ACTIVE) begin
          st_next = cnp_pkg::CNP_ST_SLEEP; // see R15
        end
      end
    endcase
    if (cmd_valid && cmd_ok) begin
      unique case (cmd_code)
        cnp_pkg::CMD_RESET: begin
          st_next = cnp_pkg::CNP_ST_POR; // see R22
          tmr_next = 32'h0;
          mode_next = cnp_pkg::CNP_MODE_DIFF;
          duty_next = '0;
          pol_next = 1'b0;
          f2s_next = 1'b0;
          done_next = '0;
        end
        cnp_pkg::CMD_ENUMERATE: st_next = cnp_pkg::CNP_ST_SLEEP; // see R15
        cnp_pkg::CMD_SLEEP: st_next = cnp_pkg::CNP_ST_SLEEP; // see R15
        cnp_pkg::CMD_LOW_POWER: st_next = cnp_pkg::CNP_ST_LOWPWR; // see R20
        cnp_pkg::CMD_ACTIVE: begin
          if (!fault_present && st_reg != cnp_pkg::CNP_ST_ACTIVE) begin // see R17
            st_next = cnp_pkg::CNP_ST_ACTIVE;
            done_next = '0;
          end
        end
        cnp_pkg::CMD_WRITE_SETUP: begin
          pol_next = cmd_data[0]; // see R4
          f2s_next = cmd_data[1];
        end
        cnp_pkg::CMD_WRITE_DUTY: begin
          for (int i = 0; i < NCH; i++) begin
            if (cmd_broadcast || cmd_channel == 2'(i)) begin
              duty_next[i*16 +: 16] = cmd_data; // see R16
            end
          end
        end
        default: ;
      endcase
    end
    // one check per channel above minimum, rearmed when duty falls to or below it
    for (int i = 0; i < NCH; i++) begin
      if (duty_reg[i*16 +: 16] <= cnp_pkg::DUTY_MIN) begin
        done_next[i] = 1'b0;
      end else if (st_reg == cnp_pkg::CNP_ST_ACTIVE && !done_reg[i]) begin
        chk_next[i] = 1'b1; // see R19
        done_next[i] = 1'b1;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      drv_next[i] = (st_next == cnp_pkg::CNP_ST_ACTIVE) && (duty_next[i*16 +: 16] != cnp_pkg::DUTY_RESET); // see R18
    end
    lic_next = (mode_next == cnp_pkg::CNP_MODE_EOC); // see R23
  end

  // upstream sender: host/end-of-chain use data+clock, transceiver manchester on pos
  always_comb begin
    up_next = up_reg;
    div_next = tick ? 5'h00 : div_reg + 5'h01;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rdy_next = 1'b0;
    po_next = idle_p;
    no_next = idle_n;
    // host mode shares pos with the host's sender, so it is driven only around a frame
    poe_next = (mode_reg == cnp_pkg::CNP_MODE_EOC || mode_reg == cnp_pkg::CNP_MODE_XCVR) || (mode_reg == cnp_pkg::CNP_MODE_MCU
      && (up_valid || up_reg != CNP_UP_IDLE || (poe_reg && po_reg != idle_p))); // see R5
    noe_next = (mode_reg == cnp_pkg::CNP_MODE_MCU || mode_reg == cnp_pkg::CNP_MODE_EOC); // see R8
    if (st_reg == cnp_pkg::CNP_ST_POR || st_reg == cnp_pkg::CNP_ST_DETECT) begin
      poe_next = 1'b0;
      noe_next = 1'b0;
    end
    unique case (up_reg)
      CNP_UP_IDLE: begin
        if (up_valid && poe_next && tick) begin
          sh_next = up_data;
          rdy_next = 1'b1;
          up_next = CNP_UP_START;
        end
      end
      CNP_UP_START: begin
        po_next = !idle_p; // start: data toggles while clock rests; see R3
        if (tick) begin
          up_next = CNP_UP_DATA;
          bit_next = 4'h0;
        end
      end
      CNP_UP_DATA: begin
        if (mode_reg == cnp_pkg::CNP_MODE_XCVR) begin
          po_next = sh_reg[7] ^ (div_reg < DIV_HALF); // first half inverted, as the receiver expects
        end else begin
          po_next = sh_reg[7]; // see R3
          no_next = (div_reg >= DIV_HALF) ^ pol_reg; // see R4
        end
        if (tick) begin
          sh_next = {sh_reg[6:0], 1'b0};
          bit_next = bit_reg + 4'h1;
          if (bit_reg == BITS_LAST) begin
            up_next = CNP_UP_STOP;
          end
        end
      end
      CNP_UP_STOP: begin
        po_next = !idle_p;
        no_next = idle_n;
        if (tick) begin
          up_next = CNP_UP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= cnp_pkg::CNP_ST_POR;
      mode_reg <= cnp_pkg::CNP_MODE_DIFF;
      tmr_reg <= 32'h0;
      pol_reg <= 1'b0;
      f2s_reg <= 1'b0;
      duty_reg <= '0; // see R12
      drv_reg <= '0;
      chk_reg <= '0;
      done_reg <= '0;
      fnow_reg <= 1'b0;
      faft_reg <= 1'b0;
      lic_reg <= 1'b0;
      up_reg <= CNP_UP_IDLE;
      div_reg <= 5'h00;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      po_reg <= 1'b0;
      no_reg <= 1'b0;
      poe_reg <= 1'b0;
      noe_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      tmr_reg <= tmr_next;
      pol_reg <= pol_next;
      f2s_reg <= f2s_next;
      duty_reg <= duty_next;
      drv_reg <= drv_next;
      chk_reg <= chk_next;
      done_reg <= done_next;
      fnow_reg <= fnow_next;
      faft_reg <= faft_next;
      lic_reg <= lic_next;
      up_reg <= up_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      po_reg <= po_next;
      no_reg <= no_next;
      poe_reg <= poe_next;
      noe_reg <= noe_next;
      rdy_reg <= rdy_next;
    end
  end

  assign serial_pin_pos_out = po_reg;
  assign serial_pin_neg_out = no_reg;
  assign serial_pin_pos_oe = poe_reg;
  assign serial_pin_neg_oe = noe_reg;
  assign up_ready = rdy_reg;
  assign fwd_now = fnow_reg;
  assign fwd_after = faft_reg;
  assign node_state = st_reg;
  assign port_mode = mode_reg;
  assign last_in_chain = lic_reg; // see R23
  assign driver_en = drv_reg;
  assign duty_out = duty_reg;
  assign check_start = chk_reg;
endmodule

/* sim/cnp_node_asserts.sv */
// port assertions for the chain node
`timescale 1ns/1ns
module cnp_node_asserts #(
  parameter int NCH = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_broadcast,
  input wire logic fault_present,
  input wire logic fwd_now,
  input wire logic fwd_after,
  input wire logic [2:0] node_state,
  input wire logic [1:0] port_mode,
  input wire logic last_in_chain,
  input wire logic serial_pin_neg_oe,
  input wire logic [NCH-1:0] driver_en,
  input wire logic [NCH*16-1:0] duty_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cmd(logic [3:0] c);
    cmd_valid && cmd_code == c;
  endsequence
  a_last_chain_mode: assert property (last_in_chain == (port_mode == 2'h2))
    else $error("last_in_chain disagrees with port mode");
  a_drivers_off: assert property (node_state != 3'h4 |-> driver_en == '0)
    else $error("drivers on outside active");
  a_unconf_refuse: assert property (node_state == 3'h2 && cmd_valid && !cmd_broadcast
    && cmd_code != cnp_pkg::CMD_ENUMERATE |=> node_state == 3'h2)
    else $error("addressed command acted on while unconfigured");
  a_enum_sleep: assert property (node_state == 3'h2 ##0 s_cmd(cnp_pkg::CMD_ENUMERATE) |=> node_state == 3'h3)
    else $error("enumerate did not lead to sleep");
  a_fault_block: assert property (node_state == 3'h3 && fault_present ##0 s_cmd(cnp_pkg::CMD_ACTIVE)
    |=> node_state == 3'h3)
    else $error("active entered with fault present");
  a_go_active: assert property (node_state == 3'h3 && !fault_present ##0 s_cmd(cnp_pkg::CMD_ACTIVE)
    |=> node_state == 3'h4)
    else $error("active command not taken");
  a_low_power: assert property (node_state inside {3'h3, 3'h4} ##0 s_cmd(cnp_pkg::CMD_LOW_POWER)
    |=> node_state == 3'h5)
    else $error("low power command not taken");
  a_fwd_kind: assert property (node_state >= 3'h2 && cmd_valid |=>
    fwd_now == $past(cmd_broadcast) && fwd_after == !$past(cmd_broadcast))
    else $error("forward pulse of wrong kind");
  a_xcvr_rx_only: assert property (node_state >= 3'h2 && port_mode == 2'h3 |-> !serial_pin_neg_oe)
    else $error("negative pin driven in transceiver mode");
  a_duty_cleared: assert property (node_state == 3'h2 && $past(node_state) == 3'h1 |-> duty_out == '0)
    else $error("duty not zero after startup");
endmodule
bind cnp_node cnp_node_asserts #(.NCH(NCH)) u_asserts (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_broadcast(cmd_broadcast), .fault_present(fault_present), .fwd_now(fwd_now),
  .fwd_after(fwd_after), .node_state(node_state), .port_mode(port_mode), .last_in_chain(last_in_chain),
  .serial_pin_neg_oe(serial_pin_neg_oe), .driver_en(driver_en), .duty_out(duty_out));

/* sim/cnp_host_model.sv */
// host side model: manchester sender and upstream frame capture
`timescale 1ns/1ns
module cnp_host_model (
  input wire logic pos_w,
  input wire logic neg_w,
  input wire logic clk_inv,
  input wire logic cap_on,
  output logic pos_drv,
  output logic pos_val,
  output logic neg_drv,
  output logic neg_val,
  output logic [7:0] cap_byte,
  output logic [3:0] cap_cnt
);
  wire logic up_clk = neg_w ^ clk_inv;
  initial begin
    pos_drv = 1'b0;
    pos_val = 1'b1;
    neg_drv = 1'b0;
    neg_val = 1'b0;
  end
  // noise on the negative pin, the node must not listen to it
  always #20 neg_val = ~neg_val;
  // data taken on the restored clock's rising edge, msb first
  always @(posedge up_clk) begin
    if (cap_on) begin
      cap_byte <= {cap_byte[6:0], pos_w};
      cap_cnt <= cap_cnt + 4'h1;
    end
  end
  task automatic clear();
    cap_byte = 8'h00;
    cap_cnt = 4'h0;
  endtask
  // no transceiver is modelled; its data rate floor is a board matter
  // 64 ns link clock, each half bit two of its periods; idle between frames
  task automatic send(input logic [7:0] b);
    pos_drv = 1'b1;
    neg_drv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pos_val = ~b[i];
      #128;
      pos_val = b[i];
      #128;
    end
    pos_drv = 1'b0; // released at once so the reply is not blocked
    neg_drv = 1'b0;
  endtask
endmodule

/* sim/tb_cnp_node.sv */
// self-checking bench for the chain node
`timescale 1ns/1ns
module tb_cnp_node;
  logic ref_clk = 1'b0, rst = 1'b1, pull_pos = 1'b1, pull_neg = 1'b0, clk_inv = 1'b1, cap_on = 1'b0;
  logic cmd_valid = 1'b0, cmd_broadcast = 1'b0, fault_present = 1'b0, fault_event = 1'b0, up_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0, cap_cnt;
  logic [1:0] cmd_channel = 2'h0, port_mode;
  logic [15:0] cmd_data = 16'h0000;
  logic [7:0] up_data = 8'h00, rx_sh = 8'h00, cap_byte;
  logic pos_out, pos_oe, neg_out, neg_oe, rx_bit_valid, rx_bit_value, fwd_now, fwd_after, last_in_chain, up_ready;
  logic h_pos_drv, h_pos_val, h_neg_drv, h_neg_val;
  logic [2:0] node_state, driver_en, check_start, chk_seen = 3'h0;
  logic [47:0] duty_out;
  int error_cnt = 0, compares = 0, cyc = 0, n_now = 0, n_after = 0, rx_n = 0;
  wire logic pos_w = pos_oe ? pos_out : h_pos_drv ? h_pos_val : pull_pos;
  wire logic neg_w = neg_oe ? neg_out : h_neg_drv ? h_neg_val : pull_neg;
  always #4 ref_clk = ~ref_clk;
  cnp_node #(.STARTUP_CYCLES(200), .DETECT_CYCLES(20), .NCH(3)) dut (.ref_clk(ref_clk), .rst(rst),
    .serial_pin_pos_in(pos_w), .serial_pin_pos_out(pos_out), .serial_pin_pos_oe(pos_oe),
    .serial_pin_neg_in(neg_w), .serial_pin_neg_out(neg_out), .serial_pin_neg_oe(neg_oe),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_broadcast(cmd_broadcast), .cmd_channel(cmd_channel),
    .cmd_data(cmd_data), .fault_present(fault_present), .fault_event(fault_event), .up_valid(up_valid),
    .up_data(up_data), .up_ready(up_ready), .rx_bit_valid(rx_bit_valid), .rx_bit_value(rx_bit_value),
    .fwd_now(fwd_now), .fwd_after(fwd_after), .node_state(node_state), .port_mode(port_mode),
    .last_in_chain(last_in_chain), .driver_en(driver_en), .duty_out(duty_out), .check_start(check_start));
  cnp_host_model host (.pos_w(pos_w), .neg_w(neg_w), .clk_inv(clk_inv), .cap_on(cap_on), .pos_drv(h_pos_drv),
    .pos_val(h_pos_val), .neg_drv(h_neg_drv), .neg_val(h_neg_val), .cap_byte(cap_byte), .cap_cnt(cap_cnt));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (fwd_now) n_now <= n_now + 1;
    if (fwd_after) n_after <= n_after + 1;
    if (rx_bit_valid) begin
      rx_sh <= {rx_sh[6:0], rx_bit_value};
      rx_n <= rx_n + 1;
    end
    chk_seen <= chk_seen | check_start;
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input logic [3:0] c, input logic b, input logic [1:0] ch, input logic [15:0] d);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_broadcast = b;
    cmd_channel = ch;
    cmd_data = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wait_state(input logic [2:0] s);
    int n;
    n = 0;
    while (node_state !== s && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk(node_state, s);
  endtask
  // every strap pair, sampled again after a broadcast reset; ends in host mode
  task automatic t_straps();
    logic [1:0] m;
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 2'h1 : 2'(i);
      pull_pos = m[0];
      pull_neg = m[1];
      cmd(cnp_pkg::CMD_RESET, 1'b1, 2'h0, 16'h0000);
      wait_state(3'h2);
      chk(port_mode, m);
      chk(last_in_chain, m == 2'h2);
      chk({driver_en, duty_out}, '0);
      @(negedge ref_clk);
      chk({pos_oe, neg_oe}, (m == 2'h3) ? 2'b10 : (m == 2'h2) ? 2'b11 : (m == 2'h1) ? 2'b01 : 2'b00);
    end
  endtask
  task automatic t_manch();
    int r0;
    r0 = rx_n;
    @(negedge ref_clk);
    #3;
    // opens with a 0 bit: the receiver takes the first edge out of idle as mid-bit
    host.send(8'h5A);
    repeat (40) @(negedge ref_clk);
    chk(64'(rx_n - r0), 64'h8);
    chk(rx_sh, 8'h5A);
  endtask
  task automatic t_unconf();
    int f0, f1;
    f0 = n_now;
    f1 = n_after;
    cmd(cnp_pkg::CMD_WRITE_DUTY, 1'b0, 2'h0, 16'h0200);
    cmd(cnp_pkg::CMD_SLEEP, 1'b0, 2'h0, 16'h0000);
    chk({node_state, duty_out}, {3'h2, 48'h0});
    cmd(cnp_pkg::CMD_WRITE_SETUP, 1'b1, 2'h0, 16'h0003);
    cmd(cnp_pkg::CMD_WRITE_DUTY, 1'b1, 2'h1, 16'h0100);
    // a broadcast duty write reaches every channel
    chk(duty_out, 48'h0100_0100_0100);
    chk({32'(n_now - f0), 32'(n_after - f1)}, {32'h2, 32'h2});
    cmd(cnp_pkg::CMD_ENUMERATE, 1'b1, 2'h0, 16'h0000);
    chk(node_state, 3'h3);
  endtask
  task automatic t_states();
    cmd(cnp_pkg::CMD_WRITE_DUTY, 1'b0, 2'h0, 16'h0008);
    cmd(cnp_pkg::CMD_WRITE_DUTY, 1'b0, 2'h2, 16'h0020);
    chk({driver_en, duty_out}, {3'h0, 48'h0020_0100_0008});
    fault_present = 1'b1;
    cmd(cnp_pkg::CMD_ACTIVE, 1'b0, 2'h0, 16'h0000);
    chk(node_state, 3'h3);
    fault_present = 1'b0;
    chk_seen = 3'h0;
    cmd(cnp_pkg::CMD_ACTIVE, 1'b0, 2'h0, 16'h0000);
    repeat (4) @(negedge ref_clk);
    chk({node_state, driver_en, chk_seen}, {3'h4, 3'h7, 3'h6});
    fault_event = 1'b1;
    @(negedge ref_clk);
    fault_event = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({node_state, driver_en}, {3'h3, 3'h0});
    cmd(cnp_pkg::CMD_ACTIVE, 1'b0, 2'h0, 16'h0000);
    cmd(cnp_pkg::CMD_SLEEP, 1'b0, 2'h0, 16'h0000);
    chk({node_state, duty_out}, {3'h3, 48'h0020_0100_0008});
    cmd(cnp_pkg::CMD_ACTIVE, 1'b0, 2'h0, 16'h0000);
    cmd(cnp_pkg::CMD_LOW_POWER, 1'b0, 2'h0, 16'h0000);
    chk({node_state, driver_en}, {3'h5, 3'h0});
  endtask
  // window covers start and data bits and runs into the stop bit, but stop framing adds no edge
  task automatic t_upstream();
    int n;
    @(negedge ref_clk);
    up_data = 8'hA5;
    up_valid = 1'b1;
    n = 0;
    while (up_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    up_valid = 1'b0;
    host.clear();
    cap_on = 1'b1;
    repeat (80) @(negedge ref_clk);
    chk(neg_oe, 1'b1);
    repeat (70) @(negedge ref_clk);
    cap_on = 1'b0;
    chk({cap_cnt, cap_byte}, {4'h8, 8'hA5});
    repeat (40) @(negedge ref_clk);
    chk({pos_w, neg_w}, 2'b10);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (190) @(negedge ref_clk);
    chk(node_state == 3'h2, 1'b0);
    wait_state(3'h2);
    chk({port_mode, driver_en, duty_out}, {2'h1, 51'h0});
    t_straps();
    t_manch();
    t_unconf();
    t_states();
    t_upstream();
    close_out();
  end
endmodule
